// >>> hdl/can_accept_select.sv
// Priority selector that assigns an incoming frame to a receive object.
`timescale 1ns/1ns
module can_accept_select
    import can_sched_pkg::*;
(
    input  wire logic [NUM_OBJECTS-1:0] match_in,
    output logic      [NUM_OBJECTS-1:0] grant_out,
    output logic                        any_out
);
    // Lowest index wins; the last object is considered only when no other
    // object matched, so it acts as the catch-all listener.
    always_comb begin
        grant_out = '0;
        any_out   = 1'b0;
        for (int i = 0; i < NUM_OBJECTS; i++) begin
            if (match_in[i] && !any_out && i != LAST_OBJECT_IDX) begin
                grant_out[i] = 1'b1;
                any_out      = 1'b1;
            end
        end
        if (!any_out && match_in[LAST_OBJECT_IDX]) begin
            grant_out[LAST_OBJECT_IDX] = 1'b1;
            any_out                    = 1'b1;
        end
    end
endmodule

// >>> hdl/can_sched_pkg.sv
// Constants shared by the transmit scheduling and receive acceptance logic.
package can_sched_pkg;
    localparam int unsigned NUM_OBJECTS     = 15;
    localparam int unsigned LAST_OBJECT_IDX = 14;
    localparam int unsigned ID_WIDTH        = 29;
    localparam int unsigned CLK_MHZ         = 250;
    // Bit time of the nominal bus rate, in nanoseconds.
    localparam int unsigned BIT_TIME_NS     = 1000;
    localparam int unsigned CLK_PERIOD_NS   = 1000 / CLK_MHZ;
    localparam int unsigned BIT_CYCLES      =
        (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] BIT_CYCLES_M1   = 10'(BIT_CYCLES - 1);
    // Intermission lengths in bit times.
    localparam logic [2:0] SHORT_IFS_BITS  = 3'h3;
    localparam logic [2:0] LONG_IFS_BITS   = 3'h4;
    localparam logic [2:0] IFS_RESET       = 3'h0;
    localparam logic [9:0] PRESCALE_RESET  = 10'h000;
endpackage

// >>> hdl/can_tx_retry_rx_accept.sv
// Transmit start and retry scheduling with receive object acceptance.
`timescale 1ns/1ns
module can_tx_retry_rx_accept
    import can_sched_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   eof_done_in,
    input  wire logic                   eof_bit6_in,
    input  wire logic                   frame_good_in,
    input  wire logic                   dlc_start_in,
    input  wire logic                   bus_recessive_in,
    input  wire logic                   bus_busy_in,
    input  wire logic                   arb_lost_in,
    input  wire logic                   tx_pending_in,
    input  wire logic                   tx_started_in,
    input  wire logic [NUM_OBJECTS-1:0] rx_enable_in,
    input  wire logic [NUM_OBJECTS-1:0] filter_match_in,
    output logic                        tx_start_out,
    output logic [NUM_OBJECTS-1:0]      receive_ok_flag_out,
    output logic [NUM_OBJECTS-1:0]      rx_done_out,
    output logic                        eom_irq_out
);
    typedef enum logic [1:0] {IDLE, IFS_COUNT, READY} sched_t;

    sched_t                   state;
    sched_t                   next_state;
    logic [9:0]               prescale;
    logic [9:0]               next_prescale;
    logic [2:0]               ifs_count;
    logic [2:0]               next_ifs_count;
    logic [2:0]               ifs_need;
    logic [2:0]               next_ifs_need;
    logic                     lost;
    logic                     next_lost;
    logic                     tx_start;
    logic                     next_tx_start;
    logic [NUM_OBJECTS-1:0]   latched_grant;
    logic [NUM_OBJECTS-1:0]   next_latched_grant;
    logic                     claimed;
    logic                     next_claimed;
    logic [NUM_OBJECTS-1:0]   rx_ok;
    logic [NUM_OBJECTS-1:0]   next_rx_ok;
    logic [NUM_OBJECTS-1:0]   rx_done;
    logic [NUM_OBJECTS-1:0]   next_rx_done;
    logic                     irq;
    logic                     next_irq;
    logic [NUM_OBJECTS-1:0]   grant;
    logic                     any_grant;
    logic                     bit_tick;

    // Only enabled objects whose filter matches compete for the frame.
    can_accept_select u_select (
        .match_in  (filter_match_in & rx_enable_in),
        .grant_out (grant),
        .any_out   (any_grant)
    );

    assign bit_tick = (prescale == BIT_CYCLES_M1);

    // Scheduler: counts recessive bit times after end-of-frame.
    always_comb begin
        next_state     = state;
        next_prescale  = prescale;
        next_ifs_count = ifs_count;
        next_ifs_need  = ifs_need;
        next_lost      = lost;
        next_tx_start  = 1'b0;
        if (arb_lost_in) begin
            next_lost = 1'b1;
        end
        unique case (state)
            IDLE: begin
                if (eof_done_in) begin
                    next_state     = IFS_COUNT;
                    next_prescale  = PRESCALE_RESET;
                    next_ifs_count = IFS_RESET;
                    // Defect kept: a lost frame that no object claimed costs an extra bit.
                    if (lost && !claimed) begin
                        next_ifs_need = LONG_IFS_BITS;
                    end else begin
                        next_ifs_need = SHORT_IFS_BITS;
                    end
                    next_lost = 1'b0;
                end
            end
            IFS_COUNT: begin
                if (!bus_recessive_in) begin
                    next_state = IDLE;
                end else if (bit_tick) begin
                    next_prescale  = PRESCALE_RESET;
                    next_ifs_count = ifs_count + 3'h1;
                    if (ifs_count + 3'h1 == ifs_need) begin
                        next_state = READY;
                    end
                end else begin
                    next_prescale = prescale + 10'h001;
                end
            end
            READY: begin
                if (tx_pending_in && !tx_started_in) begin
                    next_tx_start = 1'b1;
                end
                if (tx_started_in || bus_busy_in) begin
                    next_state = IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state     <= IDLE;
            prescale  <= PRESCALE_RESET;
            ifs_count <= IFS_RESET;
            ifs_need  <= SHORT_IFS_BITS;
            lost      <= 1'b0;
            tx_start  <= 1'b0;
        end else begin
            state     <= next_state;
            prescale  <= next_prescale;
            ifs_count <= next_ifs_count;
            ifs_need  <= next_ifs_need;
            lost      <= next_lost;
            tx_start  <= next_tx_start;
        end
    end

    // Acceptance is decided at the length field and published after EOF
    // bit six; a host clear in the same cycle loses to a new set.
    always_comb begin
        next_latched_grant = latched_grant;
        next_claimed       = claimed;
        next_rx_ok         = rx_ok & rx_enable_in;
        next_rx_done       = '0;
        next_irq           = 1'b0;
        if (dlc_start_in) begin
            next_latched_grant = grant;
            next_claimed       = any_grant;
        end
        if (eof_bit6_in && frame_good_in) begin
            next_rx_ok   = next_rx_ok | latched_grant;
            next_rx_done = latched_grant;
            next_irq     = |latched_grant;
        end
        if (eof_done_in) begin
            next_latched_grant = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            latched_grant <= '0;
            claimed       <= 1'b0;
            rx_ok         <= '0;
            rx_done       <= '0;
            irq           <= 1'b0;
        end else begin
            latched_grant <= next_latched_grant;
            claimed       <= next_claimed;
            rx_ok         <= next_rx_ok;
            rx_done       <= next_rx_done;
            irq           <= next_irq;
        end
    end

    assign tx_start_out        = tx_start;
    assign receive_ok_flag_out = rx_ok;
    assign rx_done_out         = rx_done;
    assign eom_irq_out         = irq;

    // Ok flag appears one cycle after EOF bit six for the granted object.
    rx_ok_timing_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        eof_bit6_in && frame_good_in && (|latched_grant)
        |=> ((rx_ok & $past(latched_grant)) == $past(latched_grant)))
        else $error("receive ok not set after end-of-frame bit six");

    irq_with_ok_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        eom_irq_out |-> (|(rx_done_out & receive_ok_flag_out)))
        else $error("interrupt without receive completion");

    last_lowest_prio_a: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        grant[LAST_OBJECT_IDX] |-> !(|(filter_match_in & rx_enable_in
            & ~(15'h1 << LAST_OBJECT_IDX))))
        else $error("last object took a frame another object accepted");

    one_grant_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $onehot0(grant))
        else $error("frame granted to more than one object");

    long_ifs_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state == IDLE && eof_done_in && lost && !claimed
        |=> ifs_need == LONG_IFS_BITS)
        else $error("unclaimed lost frame did not use long intermission");

    short_ifs_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state == IDLE && eof_done_in && !(lost && !claimed)
        |=> ifs_need == SHORT_IFS_BITS)
        else $error("intermission not three bits");

    start_after_ifs_a: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        tx_start_out |-> $past(state) == READY)
        else $error("transmit started before intermission elapsed");

    dominant_restart_a: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        state == IFS_COUNT && !bus_recessive_in |=> state == IDLE)
        else $error("dominant bit did not abort intermission count");
endmodule

// >>> test/can_bus_node.sv
// Model of the other bus nodes, which put frames on the shared bus.
`timescale 1ns/1ns
module can_bus_node (
    input  wire logic clk_in,
    output logic      eof_done_out,
    output logic      eof_bit6_out,
    output logic      frame_good_out,
    output logic      dlc_start_out,
    output logic      bus_recessive_out,
    output logic      bus_busy_out,
    output logic      arb_lost_out
);
    // The bus idles recessive with no frame in progress.
    initial begin
        eof_done_out      = 1'b0;
        eof_bit6_out      = 1'b0;
        frame_good_out    = 1'b1;
        dlc_start_out     = 1'b0;
        bus_recessive_out = 1'b1;
        bus_busy_out      = 1'b0;
        arb_lost_out      = 1'b0;
    end

    // One frame: arbitration, length field, end of frame, then idle.
    task automatic send_frame(input logic good, input logic lose);
        @(posedge clk_in);
        bus_busy_out      <= 1'b1;
        bus_recessive_out <= 1'b0;
        arb_lost_out      <= lose;
        @(posedge clk_in);
        arb_lost_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        dlc_start_out <= 1'b1;
        @(posedge clk_in);
        dlc_start_out <= 1'b0;
        repeat (20) @(posedge clk_in);
        bus_recessive_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        eof_bit6_out   <= 1'b1;
        frame_good_out <= good;
        @(posedge clk_in);
        eof_bit6_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        eof_done_out <= 1'b1;
        bus_busy_out <= 1'b0;
        @(posedge clk_in);
        eof_done_out   <= 1'b0;
        frame_good_out <= 1'b1;
    endtask

    // Our own frame holds the bus dominant, then ends with its end of frame.
    // Every node counts a fresh intermission from that point on.
    task automatic own_frame();
        @(posedge clk_in);
        bus_busy_out      <= 1'b1;
        bus_recessive_out <= 1'b0;
        repeat (30) @(posedge clk_in);
        bus_recessive_out <= 1'b1;
        repeat (10) @(posedge clk_in);
        eof_done_out <= 1'b1;
        bus_busy_out <= 1'b0;
        @(posedge clk_in);
        eof_done_out <= 1'b0;
    endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for transmit retry timing and receive acceptance.
`timescale 1ns/1ns
module testbench;
    import can_sched_pkg::*;
    logic                   clk_in       = 1'b0;
    logic                   sys_rst_in   = 1'b1;
    logic                   tx_pending   = 1'b0;
    logic                   tx_started   = 1'b0;
    logic [NUM_OBJECTS-1:0] rx_enable    = '0;
    logic [NUM_OBJECTS-1:0] filter_match = '0;
    logic [NUM_OBJECTS-1:0] seen_done    = '0;
    logic                   eof_done, eof_bit6, frame_good, dlc_start;
    logic                   bus_rec, bus_busy, arb_lost, tx_start_out;
    logic [NUM_OBJECTS-1:0] receive_ok_flag_out, rx_done_out;
    logic                   eom_irq_out;
    int                     irq_cnt    = 0;
    int                     fail_count = 0;
    int                     compares   = 0;

    always #2 clk_in = ~clk_in;

    can_bus_node node (.clk_in(clk_in), .eof_done_out(eof_done),
        .eof_bit6_out(eof_bit6), .frame_good_out(frame_good),
        .dlc_start_out(dlc_start), .bus_recessive_out(bus_rec),
        .bus_busy_out(bus_busy), .arb_lost_out(arb_lost));

    can_tx_retry_rx_accept uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .eof_done_in(eof_done), .eof_bit6_in(eof_bit6),
        .frame_good_in(frame_good), .dlc_start_in(dlc_start),
        .bus_recessive_in(bus_rec), .bus_busy_in(bus_busy),
        .arb_lost_in(arb_lost), .tx_pending_in(tx_pending),
        .tx_started_in(tx_started), .rx_enable_in(rx_enable),
        .filter_match_in(filter_match), .tx_start_out(tx_start_out),
        .receive_ok_flag_out(receive_ok_flag_out),
        .rx_done_out(rx_done_out), .eom_irq_out(eom_irq_out));

    // Gathers completion pulses and interrupt pulses of each frame.
    always @(posedge clk_in) begin
        if (rx_done_out !== '0) seen_done <= seen_done | rx_done_out;
        if (eom_irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task automatic check_vec(string name, logic [NUM_OBJECTS-1:0] exp,
                             logic [NUM_OBJECTS-1:0] seen);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_cnt(string name, int lo, int hi, int seen);
        compares++;
        if (seen < lo || seen > hi) begin
            fail_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi,
                     seen);
        end
    endtask

    // Cycles from end of frame to start permission, then our SOF begins.
    task automatic measure(string name, int need);
        int n;
        n = 0;
        while (tx_start_out !== 1'b1 && n < 2000) begin
            @(posedge clk_in);
            n++;
        end
        check_cnt(name, need * BIT_CYCLES - 2, need * BIT_CYCLES + 4, n);
        tx_started <= 1'b1;
        @(posedge clk_in);
        tx_started <= 1'b0;
        tx_pending <= 1'b0;
        // The started frame runs to its end, so a new intermission follows.
        node.own_frame();
    endtask

    // Starts our frame on an idle bus, then loses arbitration in it.
    task automatic lose_frame(logic good);
        int n;
        n = 0;
        seen_done <= '0;
        irq_cnt   <= 0;
        tx_pending <= 1'b1;
        while (tx_start_out !== 1'b1 && n < 2000) begin
            @(posedge clk_in);
            n++;
        end
        check_cnt("start after own frame", 3 * BIT_CYCLES - 2,
                  3 * BIT_CYCLES + 4, n);
        tx_started <= 1'b1;
        fork
            node.send_frame(good, 1'b1);
            begin @(posedge clk_in); tx_started <= 1'b0; end
        join
    endtask

    task automatic test_first_tx();
        fork
            node.send_frame(1'b1, 1'b0);
            begin repeat (4) @(posedge clk_in); tx_pending <= 1'b1; end
        join
        measure("start delay", 3);
        $display("test_first_tx done");
    endtask

    task automatic test_retry_accept();
        rx_enable    <= 15'h4008;
        filter_match <= 15'h4008;
        lose_frame(1'b1);
        measure("retry accepted", 3);
        check_vec("rx done", 15'h0008, seen_done);
        check_vec("ok flag", 15'h0008, receive_ok_flag_out);
        check_cnt("irq count", 1, 1, irq_cnt);
        rx_enable <= 15'h0000;
        repeat (2) @(posedge clk_in);
        check_vec("ok clear", 15'h0000, receive_ok_flag_out);
        $display("test_retry_accept done");
    endtask

    task automatic test_retry_none();
        filter_match <= 15'h7fff;
        lose_frame(1'b1);
        measure("retry unclaimed", 4);
        check_vec("no done", 15'h0000, seen_done);
        check_cnt("no irq", 0, 0, irq_cnt);
        $display("test_retry_none done");
    endtask

    task automatic test_last_object();
        rx_enable    <= 15'h4020;
        filter_match <= 15'h4200;
        lose_frame(1'b1);
        measure("retry last object", 3);
        check_vec("last done", 15'h4000, seen_done);
        check_vec("last ok", 15'h4000, receive_ok_flag_out);
        check_cnt("last irq", 1, 1, irq_cnt);
        $display("test_last_object done");
    endtask

    task automatic test_bad_frame();
        rx_enable    <= 15'h0008;
        filter_match <= 15'h0008;
        seen_done    <= '0;
        irq_cnt      <= 0;
        node.send_frame(1'b0, 1'b0);
        repeat (4) @(posedge clk_in);
        check_vec("bad done", 15'h0000, seen_done);
        check_vec("bad ok", 15'h0000, receive_ok_flag_out);
        check_cnt("bad irq", 0, 0, irq_cnt);
        $display("test_bad_frame done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        test_first_tx();
        test_retry_accept();
        test_retry_none();
        test_last_object();
        test_bad_frame();
        tally_and_finish();
    end
endmodule
